//--- logic/buffer_pkg.sv
// types of the configurable registered command buffer
`include "buffer_regs.svh"

package buffer_pkg;

  typedef enum logic [1:0] {MODE_WIDE, MODE_FAN_A, MODE_FAN_B} mode_e;

  typedef struct packed {
    logic                   load;
    logic                   sel;
    logic                   odt;
    logic                   cke;
    logic [`CMD_BITS-1:0]   bits;
  } cmd_word_s;

  // width_mode_sel low always means one-to-one
  function automatic mode_e decode_mode(input logic variant, input logic width);
    if (!width)
    begin
      decode_mode = MODE_WIDE;
    end
    else if (variant)
    begin
      decode_mode = MODE_FAN_B;
    end
    else
    begin
      decode_mode = MODE_FAN_A;
    end
  endfunction : decode_mode

  function automatic logic [`CMD_BITS-1:0] lane_mask(input mode_e mode);
    case (mode)
      MODE_WIDE:  lane_mask = `MASK_WIDE;
      MODE_FAN_A: lane_mask = `MASK_FAN_A;
      MODE_FAN_B: lane_mask = `MASK_FAN_B;
      default:    lane_mask = `CMD_RESET;
    endcase
  endfunction : lane_mask

endpackage : buffer_pkg

//--- logic/buffer_regs.svh
// constants of the configurable registered command buffer
`ifndef BUFFER_REGS_SVH
`define BUFFER_REGS_SVH

// ==========================================================
// widths
`define CMD_BITS        25
`define COPY_BITS       14
`define WORD_BITS       29

// ==========================================================
// active input lanes per mode, bit n at position n-1
`define MASK_WIDE       25'h1FFFFB6
`define MASK_FAN_A      25'h0003FB6
`define MASK_FAN_B      25'h0001BBF

// ==========================================================
// reset values
`define CMD_RESET       25'h0000000
`define COPY_RESET      14'h0000
`define CFG_RESET       2'h0

`endif

//--- logic/configurable_registered_buffer.sv
// configurable registered command buffer, one-to-one or one-to-two
`timescale 1ns/10ps

module configurable_registered_buffer
  import buffer_pkg::*;
#(
  parameter int FIFO_DEPTH = 2
) (
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst_b,
  // configuration pins
  input  wire logic                  fanout_variant_sel,
  input  wire logic                  width_mode_sel,
  input  wire logic                  reserved_imp_hi,
  input  wire logic                  reserved_imp_lo,
  // command inputs from the controller
  input  wire logic                  cmd_in_valid,
  output wire logic                  cmd_in_ready,
  input  wire logic [`CMD_BITS:1]    cmd_in_bits,
  input  wire logic                  primary_select_n,
  input  wire logic                  secondary_select_n,
  input  wire logic                  termination_in,
  input  wire logic                  clk_enable_in,
  // receiver enable
  output wire logic                  receivers_enabled,
  // command outputs to the memory devices
  output wire logic                  cmd_out_valid,
  input  wire logic                  cmd_out_ready,
  output wire logic [`CMD_BITS:1]    cmd_out_bits,
  output wire logic [`COPY_BITS:1]   cmd_out_copy_a,
  output wire logic [`COPY_BITS:1]   cmd_out_copy_b,
  output wire logic                  select_out,
  output wire logic                  select_out_a,
  output wire logic                  select_out_b,
  output wire logic                  termination_out,
  output wire logic                  termination_out_a,
  output wire logic                  termination_out_b,
  output wire logic                  clk_enable_out,
  output wire logic                  clk_enable_out_a,
  output wire logic                  clk_enable_out_b
);

  // ==========================================================
  // configuration synchroniser
  logic [1:0]           cfg_meta_reg;
  logic [1:0]           cfg_sync_reg;
  logic                 rx_en_reg;
  mode_e                mode;

  // reserved impedance pins are deliberately left unread

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cfg_meta_reg <= `CFG_RESET;
      cfg_sync_reg <= `CFG_RESET;
      rx_en_reg    <= 1'b0;
    end
    else
    begin
      cfg_meta_reg <= {width_mode_sel, fanout_variant_sel};
      cfg_sync_reg <= cfg_meta_reg;
      rx_en_reg    <= 1'b1;
    end
  end

  assign mode              = decode_mode(cfg_sync_reg[0], cfg_sync_reg[1]);
  assign receivers_enabled = rx_en_reg;

  // ==========================================================
  // capture into the buffer
  word_stream_if #(.WIDTH(`WORD_BITS)) cap_if ();
  word_stream_if #(.WIDTH(`WORD_BITS)) out_if ();
  cmd_word_s            cap_word;

  lane_mapper u_mapper (
    .mode               (mode),
    .cmd_in_bits        (cmd_in_bits),
    .primary_select_n   (primary_select_n),
    .secondary_select_n (secondary_select_n),
    .termination_in     (termination_in),
    .clk_enable_in      (clk_enable_in),
    .word               (cap_word)
  );

  // words are accepted only while receivers are live
  assign cap_if.valid  = cmd_in_valid && rx_en_reg;
  assign cap_if.word   = cap_word;
  assign cmd_in_ready  = cap_if.ready && rx_en_reg;

  word_fifo #(
    .WIDTH (`WORD_BITS),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk   (clk),
    .rst_b (rst_b),
    .fill  (cap_if),
    .drain (out_if)
  );

  // ==========================================================
  // output registers
  cmd_word_s            head;
  wire                  take;
  wire                  fan;
  logic [`CMD_BITS:1]   data_reg;
  logic [`CMD_BITS:1]   data_next;
  logic                 sel_reg;
  logic                 odt_reg;
  logic                 cke_reg;
  logic                 valid_reg;
  logic                 fan_reg;

  assign head         = cmd_word_s'(out_if.word);
  assign out_if.ready = cmd_out_ready;
  assign take         = out_if.valid && cmd_out_ready;
  assign fan          = (mode != MODE_WIDE);
  assign data_next    = head.load ? head.bits : data_reg;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      data_reg  <= `CMD_RESET;
      sel_reg   <= 1'b0;
      odt_reg   <= 1'b0;
      cke_reg   <= 1'b0;
      valid_reg <= 1'b0;
      fan_reg   <= 1'b0;
    end
    else
    begin
      valid_reg <= take;
      fan_reg   <= fan;
      if (take)
      begin
        data_reg <= data_next;
        sel_reg  <= head.sel;
        odt_reg  <= head.odt;
        cke_reg  <= head.cke;
      end
    end
  end

  // ==========================================================
  // pin steering per mode
  wire [`COPY_BITS:1]   copy_bits;

  assign copy_bits         = fan_reg ? data_reg[`COPY_BITS:1] : `COPY_RESET;
  assign cmd_out_valid     = valid_reg;
  assign cmd_out_bits      = fan_reg ? `CMD_RESET : data_reg;
  assign cmd_out_copy_a    = copy_bits;
  assign cmd_out_copy_b    = copy_bits;
  assign select_out        = !fan_reg && sel_reg;
  assign select_out_a      = fan_reg && sel_reg;
  assign select_out_b      = fan_reg && sel_reg;
  assign termination_out   = !fan_reg && odt_reg;
  assign termination_out_a = fan_reg && odt_reg;
  assign termination_out_b = fan_reg && odt_reg;
  assign clk_enable_out    = !fan_reg && cke_reg;
  assign clk_enable_out_a  = fan_reg && cke_reg;
  assign clk_enable_out_b  = fan_reg && cke_reg;

endmodule : configurable_registered_buffer

//--- logic/lane_mapper.sv
// gathers the active command lanes of the selected mode into a word
`timescale 1ns/10ps

module lane_mapper
  import buffer_pkg::*;
(
  // configuration
  input wire mode_e               mode,
  // pins
  input wire logic [`CMD_BITS:1]  cmd_in_bits,
  input wire logic                primary_select_n,
  input wire logic                secondary_select_n,
  input wire logic                termination_in,
  input wire logic                clk_enable_in,
  // result
  output cmd_word_s               word
);

  wire [`CMD_BITS-1:0] mask;

  assign mask      = lane_mask(mode);
  assign word.bits = cmd_in_bits & mask;
  assign word.load = !(primary_select_n && secondary_select_n);
  assign word.sel  = primary_select_n;
  assign word.odt  = termination_in;
  assign word.cke  = clk_enable_in;

endmodule : lane_mapper

//--- logic/word_fifo.sv
// small valid/ready fifo holding captured command words
`timescale 1ns/10ps

module word_fifo #(
  parameter int WIDTH = 29,
  parameter int DEPTH = 2
) (
  // clock and reset
  input wire logic  clk,
  input wire logic  rst_b,
  // streams
  word_stream_if.snk fill,
  word_stream_if.src drain
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wr_ptr_reg;
  logic [PW-1:0]    rd_ptr_reg;
  logic [PW:0]      count_reg;
  wire              push;
  wire              pop;

  assign fill.ready  = (count_reg != (PW+1)'(DEPTH));
  assign drain.valid = (count_reg != '0);
  assign drain.word  = mem[rd_ptr_reg];
  assign push        = fill.valid && fill.ready;
  assign pop         = drain.valid && drain.ready;

  function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
    bump = (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
  endfunction : bump

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end
    else
    begin
      if (push)
        wr_ptr_reg <= bump(wr_ptr_reg);
      if (pop)
        rd_ptr_reg <= bump(rd_ptr_reg);
      count_reg <= count_reg + (PW+1)'(push) - (PW+1)'(pop);
    end
  end

  always_ff @(posedge clk)
  begin
    if (push)
      mem[wr_ptr_reg] <= fill.word;
  end

endmodule : word_fifo

//--- logic/word_stream_if.sv
// valid/ready word stream between the buffer's own modules
`timescale 1ns/10ps

interface word_stream_if #(parameter int WIDTH = 29);
  logic             valid;
  logic             ready;
  logic [WIDTH-1:0] word;

  modport src (output valid, output word, input ready);
  modport snk (input valid, input word, output ready);
endinterface : word_stream_if

//--- tb/buffer_props.sv
// port assertions of the registered command buffer
`timescale 1ns/10ps

module buffer_props (
  // clock and reset
  input wire logic        clk,
  input wire logic        rst_b,
  // handshakes
  input wire logic        cmd_in_valid,
  input wire logic        cmd_in_ready,
  input wire logic        receivers_enabled,
  input wire logic        cmd_out_valid,
  // outputs
  input wire logic [25:1] cmd_out_bits,
  input wire logic [14:1] cmd_out_copy_a,
  input wire logic [14:1] cmd_out_copy_b,
  input wire logic        select_out,
  input wire logic        select_out_a,
  input wire logic        select_out_b,
  input wire logic        termination_out_a,
  input wire logic        termination_out_b,
  input wire logic        clk_enable_out_a,
  input wire logic        clk_enable_out_b
);
  // ==========================================================
  // checks
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);

  a_reset_low:
  assert property (disable iff (1'b0) !rst_b |-> !cmd_out_valid && !cmd_in_ready
    && cmd_out_bits == 25'h0000000 && cmd_out_copy_a == 14'h0000 && !receivers_enabled
    && !select_out && !select_out_a && !termination_out_a && !clk_enable_out_a)
    else $error("not low in reset");
  a_copy_equal:
  assert property (cmd_out_copy_a == cmd_out_copy_b) else $error("copies differ");
  a_ctl_copies:
  assert property ({select_out_a, termination_out_a, clk_enable_out_a}
    == {select_out_b, termination_out_b, clk_enable_out_b}) else $error("ctl copies differ");
  a_ready_gated:
  assert property (!receivers_enabled |-> !cmd_in_ready) else $error("ready while disabled");
  a_recv_live:
  assert property ($past(rst_b) |-> receivers_enabled) else $error("receivers still off");
  a_hold_idle:
  assert property (!cmd_out_valid |-> $stable(cmd_out_bits) && $stable(cmd_out_copy_a))
    else $error("outputs moved without load");
  a_mode_excl:
  assert property (|cmd_out_bits |-> cmd_out_copy_a == 14'h0000 && !select_out_a)
    else $error("both output sets active");
  a_wide_lanes:
  assert property (!cmd_out_bits[1] && !cmd_out_bits[4] && !cmd_out_bits[7])
    else $error("inactive lane driven");
  a_answer_bound:
  assert property (cmd_in_valid && cmd_in_ready |-> ##[1:40] cmd_out_valid)
    else $error("captured word never output");
endmodule : buffer_props

//--- tb/memory_sink.sv
// memory side model: accepts every word, loaded or not, with random stalls
`timescale 1ns/10ps

module memory_sink (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // control
  input wire logic stall,
  output logic     cmd_out_ready
);
  int seed = 7;

  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
      cmd_out_ready <= 1'b0;
    else
      cmd_out_ready <= !stall && ($random(seed) % 4 != 0);
endmodule : memory_sink

//--- tb/testbench.sv
// self-checking bench of the registered command buffer
`timescale 1ns/10ps
`include "buffer_regs.svh"

module testbench;
  import buffer_pkg::*;
  logic clk, rst_b, stall, vsel, wsel, zhi, zlo, in_valid, in_ready, recv_en;
  logic psel_n, ssel_n, term, cke, out_valid, out_ready, sel_o, term_o, cke_o;
  logic [25:1] in_bits, out_bits, prev;
  logic [14:1] cp_a, cp_b;
  logic [2:0]  ctl_a, ctl_b;
  int          seed = 15, miscompares = 0, checked = 0;
  cmd_word_s   q[$], w;

  configurable_registered_buffer configurable_registered_buffer_inst (
    .clk(clk), .rst_b(rst_b), .fanout_variant_sel(vsel), .width_mode_sel(wsel),
    .reserved_imp_hi(zhi), .reserved_imp_lo(zlo), .cmd_in_valid(in_valid),
    .cmd_in_ready(in_ready), .cmd_in_bits(in_bits), .primary_select_n(psel_n),
    .secondary_select_n(ssel_n), .termination_in(term), .clk_enable_in(cke),
    .receivers_enabled(recv_en), .cmd_out_valid(out_valid), .cmd_out_ready(out_ready),
    .cmd_out_bits(out_bits), .cmd_out_copy_a(cp_a), .cmd_out_copy_b(cp_b),
    .select_out(sel_o), .select_out_a(ctl_a[2]), .select_out_b(ctl_b[2]),
    .termination_out(term_o), .termination_out_a(ctl_a[1]), .termination_out_b(ctl_b[1]),
    .clk_enable_out(cke_o), .clk_enable_out_a(ctl_a[0]), .clk_enable_out_b(ctl_b[0]));

  memory_sink memory_sink_inst (.clk(clk), .rst_b(rst_b), .stall(stall),
    .cmd_out_ready(out_ready));

  // ==========================================================
  // helpers
  task automatic chk(input string name, input logic [24:0] exp, input logic [24:0] got);
    checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : finish_test

  // inactive lanes read as zero; load clear when both selects are high
  function automatic cmd_word_s expect_word();
    cmd_word_s e;
    e.load = !(psel_n && ssel_n);
    e.sel  = psel_n;
    e.odt  = term;
    e.cke  = cke;
    e.bits = in_bits & (wsel ? (vsel ? `MASK_FAN_B : `MASK_FAN_A) : `MASK_WIDE);
    return e;
  endfunction : expect_word

  // ==========================================================
  // clock, watchdog and output monitor
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  initial
  begin
    #100000;
    miscompares++;
    finish_test();
  end

  always @(negedge clk)
    if (rst_b)
    begin
      if (out_valid !== 1'b0)
      begin
        w = q.pop_front();
        if (w.load)
          prev = w.bits;
        chk("bits", {25{!wsel}} & prev, out_bits);
        chk("copy_a", {14{wsel}} & prev[14:1], cp_a);
        chk("copy_b", {14{wsel}} & prev[14:1], cp_b);
        chk("ctl", {3{!wsel}} & {w.sel, w.odt, w.cke}, {sel_o, term_o, cke_o});
        chk("ctl_a", {3{wsel}} & {w.sel, w.odt, w.cke}, ctl_a);
        chk("ctl_b", {3{wsel}} & {w.sel, w.odt, w.cke}, ctl_b);
      end
      if (in_valid && in_ready)
        q.push_back(expect_word());
    end

  // ==========================================================
  // main sequence: every configuration, reset taken with both selects high
  initial
  begin
    {rst_b, stall, in_valid, vsel, wsel, zhi, zlo, psel_n, ssel_n, term, cke} = '0;
    in_bits = '0;
    prev = '0;
    for (int m = 0; m < 4; m++)
    begin
      @(posedge clk);
      rst_b <= 1'b0;
      {vsel, wsel} <= 2'(m);
      {psel_n, ssel_n, in_valid} <= 3'h7;
      #1 chk("rst_bits", 25'h0000000, out_bits);
      chk("rst_ctl", 25'h0000000, {cp_a, ctl_a, sel_o, term_o, cke_o, out_valid, in_ready, recv_en});
      chk("rst_copy", 25'h0000000, {cp_b, ctl_b});
      repeat (3) @(posedge clk);
      rst_b <= 1'b1;
      in_valid <= 1'b0;
      q.delete();
      prev = '0;
      repeat (4) @(posedge clk);
      repeat (300)
      begin
        @(posedge clk);
        in_valid <= $random(seed) % 4 != 0;
        in_bits <= 25'($random(seed));
        {psel_n, ssel_n, term, cke, zhi, zlo} <= 6'($random(seed));
      end
      @(posedge clk);
      stall <= 1'b1;
      in_valid <= 1'b1;
      repeat (8) @(posedge clk);
      #1 chk("full", 25'h0000000, 25'(in_ready));
      @(posedge clk);
      stall <= 1'b0;
      in_valid <= 1'b0;
      repeat (20) @(posedge clk);
      chk("drain", 25'h0000000, 25'(q.size()));
      $display("configuration %0d done", m);
    end
    finish_test();
  end
endmodule : testbench

bind configurable_registered_buffer buffer_props buffer_props_inst (
  .clk(clk), .rst_b(rst_b), .cmd_in_valid(cmd_in_valid), .cmd_in_ready(cmd_in_ready),
  .receivers_enabled(receivers_enabled), .cmd_out_valid(cmd_out_valid),
  .cmd_out_bits(cmd_out_bits), .cmd_out_copy_a(cmd_out_copy_a),
  .cmd_out_copy_b(cmd_out_copy_b), .select_out(select_out), .select_out_a(select_out_a),
  .select_out_b(select_out_b), .termination_out_a(termination_out_a),
  .termination_out_b(termination_out_b), .clk_enable_out_a(clk_enable_out_a),
  .clk_enable_out_b(clk_enable_out_b));
